// ### src/wru_top.sv
// watchdog reset unit: watchdog, reset merge and register slave
`timescale 1ns/1ps
module wru_top #(
	parameter int WDT_EXPIRE_TICKS = wru_pkg::WDT_EXPIRE_TICKS,
	parameter int RST_HOLD_CYCLES = wru_pkg::RST_HOLD_CYCLES,
	parameter int OSC_WAIT_CYCLES = wru_pkg::OSC_WAIT_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rst_pin_n,
	input wire logic por_req,
	input wire logic por_option,
	input wire logic tbt_tick,
	input wire logic wake,
	input wire logic [7:0] mem_rdata,
	output logic chip_reset_n_r,
	output logic cpu_run,
	output logic [15:0] fetch_addr,
	output logic fetch_rd,
	output logic [15:0] reset_vector,
	output logic mode_err,
	output logic sleep_mode_r,
	output logic stop_mode_r,
	output logic irq_enable_r,
	output logic wdt_running_r
);
	localparam int TW = (WDT_EXPIRE_TICKS > 2) ? $clog2(WDT_EXPIRE_TICKS) : 1;
	localparam int HW = $clog2(RST_HOLD_CYCLES + 1);

	if (WDT_EXPIRE_TICKS < 2 || RST_HOLD_CYCLES < 4) begin : g_bad_par
		$error("WDT_EXPIRE_TICKS must be at least 2 and RST_HOLD_CYCLES at least 4");
	end

	function automatic wru_pkg::wru_reg_t reg_sel(input logic [7:0] addr);
		unique case (addr)
			wru_pkg::OFF_WDT_CTRL: reg_sel = wru_pkg::REG_WDT;
			wru_pkg::OFF_STBY_CTRL: reg_sel = wru_pkg::REG_STB;
			wru_pkg::OFF_STATUS: reg_sel = wru_pkg::REG_STS;
			default: reg_sel = wru_pkg::REG_NONE;
		endcase
	endfunction

	// bus slave state
	logic aw_full_r, w_full_r;
	logic [7:0] awaddr_q_r;
	logic [31:0] wdata_q_r;
	logic wstrb0_q_r;
	logic aw_hs, w_hs, ar_hs, do_write;
	wru_pkg::wru_reg_t wsel;
	logic [31:0] rd_word;

	// block state
	logic wdt_run_r;
	logic [TW-1:0] tick_cnt_r;
	logic [HW-1:0] hold_cnt_r;
	logic osc_req_r;
	logic [3:0] cause_r;
	logic osc_wait;
	logic chip_rst, standby, key_ok, wr_wdt, wr_stb, sw_rst, standby_enter, wdt_expire, por_src, src_int;
	logic [3:0] cause_now;

	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs = s_axi_wvalid & s_axi_wready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	assign do_write = aw_full_r & w_full_r & ~s_axi_bvalid;
	assign wsel = reg_sel(awaddr_q_r);
	assign wr_wdt = do_write & wstrb0_q_r & (wsel == wru_pkg::REG_WDT);
	assign wr_stb = do_write & wstrb0_q_r & (wsel == wru_pkg::REG_STB);
	assign key_ok = wdata_q_r[wru_pkg::WDT_KEY_LSB +: 4] == wru_pkg::WDT_KEY;
	assign sw_rst = wr_stb & ~wdata_q_r[wru_pkg::STB_RSTN_BIT];
	assign standby = sleep_mode_r | stop_mode_r;
	assign standby_enter = wr_stb & ~standby & ~sw_rst
		& (wdata_q_r[wru_pkg::STB_SLEEP_BIT] | wdata_q_r[wru_pkg::STB_STOP_BIT]);
	assign chip_rst = ~chip_reset_n_r;
	// a key write in the same cycle as the final tick still saves the chip
	assign wdt_expire = wdt_run_r & tbt_tick & ~standby & ~(wr_wdt & key_ok)
		& (tick_cnt_r == TW'(WDT_EXPIRE_TICKS - 1));
	assign por_src = por_req & por_option;
	assign src_int = sw_rst | wdt_expire | por_src;
	assign cause_now = {wdt_expire, por_src, sw_rst, ~rst_pin_n};

	// write channels taken in either order, one write outstanding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awaddr_q_r <= 8'h00;
			wdata_q_r <= 32'h0000_0000;
			wstrb0_q_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= wru_pkg::RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_full_r <= 1'b1;
				awaddr_q_r <= s_axi_awaddr;
			end else if (do_write) begin
				aw_full_r <= 1'b0;
			end
			if (w_hs) begin
				w_full_r <= 1'b1;
				wdata_q_r <= s_axi_wdata;
				wstrb0_q_r <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_full_r <= 1'b0;
			end
			s_axi_awready <= ~(aw_hs | (aw_full_r & ~do_write));
			s_axi_wready <= ~(w_hs | (w_full_r & ~do_write));
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wsel == wru_pkg::REG_NONE) ? wru_pkg::RESP_SLVERR : wru_pkg::RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (reg_sel(s_axi_araddr))
			wru_pkg::REG_WDT: rd_word[wru_pkg::WDT_KEY_LSB +: 4] = wru_pkg::WDT_KEY_READ;
			wru_pkg::REG_STB: begin
				// reset bit is write-zero-to-act, so it reads one
				rd_word[wru_pkg::STB_RSTN_BIT] = 1'b1;
				rd_word[wru_pkg::STB_SLEEP_BIT] = sleep_mode_r;
				rd_word[wru_pkg::STB_STOP_BIT] = stop_mode_r;
				rd_word[wru_pkg::STB_INTINIT_BIT] = irq_enable_r;
			end
			wru_pkg::REG_STS: begin
				rd_word[wru_pkg::STS_RUN_BIT] = wdt_run_r;
				rd_word[wru_pkg::STS_CAUSE_LSB +: 4] = cause_r;
				rd_word[wru_pkg::STS_OSC_BIT] = osc_wait;
				rd_word[wru_pkg::STS_MODE_ERR_BIT] = mode_err;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= wru_pkg::RESP_OKAY;
		end else begin
			if (ar_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (reg_sel(s_axi_araddr) == wru_pkg::REG_NONE) ?
					wru_pkg::RESP_SLVERR : wru_pkg::RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			s_axi_arready <= ~(ar_hs | (s_axi_rvalid & ~s_axi_rready));
		end
	end

	// watchdog core; chip reset drops it back to stopped and unarmed
	always_ff @(posedge aclk) begin
		if (!aresetn || chip_rst) begin
			wdt_run_r <= 1'b0;
			tick_cnt_r <= '0;
		end else if (wr_wdt && key_ok) begin
			wdt_run_r <= 1'b1;
			tick_cnt_r <= '0;
		end else if (standby_enter) begin
			tick_cnt_r <= '0;
		end else if (wdt_run_r && tbt_tick && !standby) begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
		end
	end
	assign wdt_running_r = wdt_run_r;

	// standby and interrupt gate, cleared by any chip reset
	always_ff @(posedge aclk) begin
		if (!aresetn || chip_rst) begin
			sleep_mode_r <= 1'b0;
			stop_mode_r <= 1'b0;
			irq_enable_r <= 1'b0;
		end else begin
			if (wake) begin
				sleep_mode_r <= 1'b0;
				stop_mode_r <= 1'b0;
			end
			if (wr_stb && !sw_rst) begin
				if (wdata_q_r[wru_pkg::STB_SLEEP_BIT]) begin
					sleep_mode_r <= 1'b1;
				end
				if (wdata_q_r[wru_pkg::STB_STOP_BIT]) begin
					stop_mode_r <= 1'b1;
				end
				irq_enable_r <= wdata_q_r[wru_pkg::STB_INTINIT_BIT];
			end
		end
	end

	// reset merge; internal sources are stretched, the pin is followed as a level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chip_reset_n_r <= 1'b0;
			hold_cnt_r <= '0;
			osc_req_r <= 1'b0;
			cause_r <= wru_pkg::CAUSE_RESET;
		end else begin
			if (src_int) begin
				hold_cnt_r <= HW'(RST_HOLD_CYCLES - 1);
			end else if (hold_cnt_r != '0) begin
				hold_cnt_r <= hold_cnt_r - 1'b1;
			end
			chip_reset_n_r <= ~(~rst_pin_n | src_int | (hold_cnt_r != '0));
			if (por_src) begin
				osc_req_r <= 1'b1;
			end else if (!chip_rst) begin
				osc_req_r <= 1'b0;
			end
			if ((|cause_now) && !chip_rst) begin
				cause_r <= cause_now;
			end else if (|cause_now) begin
				cause_r <= cause_r | cause_now;
			end
		end
	end

	// reset only gates the core; memory sees no clear or write from here, and a
	// store cut by reset is left as the core left it
	wru_seq #(
		.OSC_WAIT_CYCLES(OSC_WAIT_CYCLES)
	) u_seq (
		.aclk(aclk),
		.aresetn(aresetn),
		.chip_rst(chip_rst),
		.osc_req(osc_req_r),
		.resume(wake & stop_mode_r),
		.mem_rdata(mem_rdata),
		.fetch_addr_r(fetch_addr),
		.fetch_rd_r(fetch_rd),
		.cpu_run_r(cpu_run),
		.reset_vector_r(reset_vector),
		.mode_err_r(mode_err),
		.osc_wait_r(osc_wait)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_wdt_start: assert property (!wdt_run_r && !chip_rst && wr_wdt && key_ok |=> wdt_run_r)
		else $error("key write did not start watchdog");
	a_wdt_badkey: assert property (!wdt_run_r && !(wr_wdt && key_ok) |=> !wdt_run_r)
		else $error("watchdog started without key");
	a_wdt_clear: assert property (wdt_run_r && !chip_rst && wr_wdt && key_ok |=> tick_cnt_r == '0)
		else $error("key write did not clear counter");
	a_wdt_nostop: assert property (wdt_run_r && !chip_rst && !wdt_expire |=> wdt_run_r)
		else $error("watchdog stopped without reset");
	a_key_readback: assert property (ar_hs && reg_sel(s_axi_araddr) == wru_pkg::REG_WDT
		|=> s_axi_rvalid && s_axi_rdata[3:0] == 4'hf)
		else $error("key bits did not read 1111");
	a_stby_clear: assert property (standby_enter && !chip_rst && !(wr_wdt && key_ok)
		|=> tick_cnt_r == '0)
		else $error("standby entry left counter set");
	a_tick_only: assert property (!tbt_tick && !chip_rst |=> $stable(tick_cnt_r) || tick_cnt_r == '0)
		else $error("counter moved without time-base tick");
	a_wdt_expire: assert property (wdt_run_r && !chip_rst && tbt_tick && !standby && !wr_wdt
		&& tick_cnt_r == TW'(WDT_EXPIRE_TICKS - 1) |=> !chip_reset_n_r [*4])
		else $error("watchdog expiry did not hold chip reset");
	a_rst_sources: assert property (!rst_pin_n || sw_rst || por_src |=> !chip_reset_n_r)
		else $error("reset source ignored");
	a_rst_stops: assert property (chip_rst |=> !wdt_run_r && !irq_enable_r)
		else $error("chip reset left watchdog or interrupts on");

	c_wdt_start: cover property (!wdt_run_r ##1 wdt_run_r);
	c_wdt_reset: cover property (wdt_expire ##1 chip_rst);
	c_sw_reset: cover property (sw_rst ##[1:1000] cpu_run);
endmodule // wru_top

// ### common/wru_pkg.sv
// shared constants and types of the watchdog reset unit
package wru_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFF_WDT_CTRL = 8'h00;
	localparam logic [7:0] OFF_STBY_CTRL = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	// watchdog_control fields
	localparam int WDT_KEY_LSB = 0;
	localparam logic [3:0] WDT_KEY = 4'h5;
	localparam logic [3:0] WDT_KEY_READ = 4'hf;
	// standby_control_register fields
	localparam int STB_RSTN_BIT = 0;
	localparam int STB_SLEEP_BIT = 1;
	localparam int STB_STOP_BIT = 2;
	localparam int STB_INTINIT_BIT = 3;
	// status fields
	localparam int STS_RUN_BIT = 0;
	localparam int STS_CAUSE_LSB = 1;
	localparam int STS_OSC_BIT = 5;
	localparam int STS_MODE_ERR_BIT = 6;
	// cause vector bit order: pin, software, power-on, watchdog
	localparam logic [3:0] CAUSE_RESET = 4'h0;
	// timing counts
	localparam int WDT_EXPIRE_TICKS = 2;
	localparam int RST_HOLD_CYCLES = 4;
	localparam int OSC_WAIT_CYCLES = 1024;
	// reset release fetch addresses
	localparam logic [15:0] VEC_MODE_ADDR = 16'hfffd;
	localparam logic [15:0] VEC_HI_ADDR = 16'hfffe;
	localparam logic [15:0] VEC_LO_ADDR = 16'hffff;
	localparam logic [7:0] MODE_BYTE_RSVD = 8'h00;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {SEQ_HOLD, SEQ_OSC, SEQ_MODE, SEQ_VHI, SEQ_VLO, SEQ_RUN} wru_seq_t;
	typedef enum logic [1:0] {REG_WDT, REG_STB, REG_STS, REG_NONE} wru_reg_t;
endpackage

// ### src/wru_seq.sv
// reset release sequencer: oscillation wait and vector fetch
`timescale 1ns/1ps
module wru_seq #(
	parameter int OSC_WAIT_CYCLES = wru_pkg::OSC_WAIT_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic chip_rst,
	input wire logic osc_req,
	input wire logic resume,
	input wire logic [7:0] mem_rdata,
	output logic [15:0] fetch_addr_r,
	output logic fetch_rd_r,
	output logic cpu_run_r,
	output logic [15:0] reset_vector_r,
	output logic mode_err_r,
	output logic osc_wait_r
);
	localparam int CW = $clog2(OSC_WAIT_CYCLES + 1);

	if (OSC_WAIT_CYCLES < 1) begin : g_bad_osc
		$error("OSC_WAIT_CYCLES must be at least 1");
	end

	wru_pkg::wru_seq_t state_r;
	logic ph_r;
	logic fetch_after_r;
	logic [CW-1:0] osc_cnt_r;

	always_ff @(posedge aclk) begin
		if (!aresetn || chip_rst) begin
			// cpu_run drops at once: instruction in flight is abandoned
			state_r <= wru_pkg::SEQ_HOLD;
			ph_r <= 1'b0;
			fetch_rd_r <= 1'b0;
			cpu_run_r <= 1'b0;
			osc_wait_r <= 1'b0;
			fetch_after_r <= 1'b0;
			osc_cnt_r <= '0;
		end else begin
			unique case (state_r)
				wru_pkg::SEQ_HOLD: begin
					if (osc_req) begin
						state_r <= wru_pkg::SEQ_OSC;
						osc_wait_r <= 1'b1;
						osc_cnt_r <= CW'(OSC_WAIT_CYCLES - 1);
						fetch_after_r <= 1'b1;
					end else begin
						state_r <= wru_pkg::SEQ_MODE;
					end
				end
				wru_pkg::SEQ_OSC: begin
					if (osc_cnt_r == '0) begin
						osc_wait_r <= 1'b0;
						state_r <= fetch_after_r ? wru_pkg::SEQ_MODE : wru_pkg::SEQ_RUN;
						cpu_run_r <= ~fetch_after_r;
					end else begin
						osc_cnt_r <= osc_cnt_r - 1'b1;
					end
				end
				wru_pkg::SEQ_MODE, wru_pkg::SEQ_VHI, wru_pkg::SEQ_VLO: begin
					// issue, wait one cycle, capture: reads are 3 cycles apart
					if (!ph_r) begin
						fetch_rd_r <= 1'b1;
						ph_r <= 1'b1;
					end else if (fetch_rd_r) begin
						fetch_rd_r <= 1'b0;
					end else begin
						ph_r <= 1'b0;
						if (state_r == wru_pkg::SEQ_MODE) begin
							state_r <= wru_pkg::SEQ_VHI;
						end else if (state_r == wru_pkg::SEQ_VHI) begin
							state_r <= wru_pkg::SEQ_VLO;
						end else begin
							state_r <= wru_pkg::SEQ_RUN;
							cpu_run_r <= 1'b1;
						end
					end
				end
				wru_pkg::SEQ_RUN: begin
					if (resume) begin
						state_r <= wru_pkg::SEQ_OSC;
						osc_wait_r <= 1'b1;
						cpu_run_r <= 1'b0;
						osc_cnt_r <= CW'(OSC_WAIT_CYCLES - 1);
						fetch_after_r <= 1'b0;
					end
				end
				default: state_r <= wru_pkg::SEQ_HOLD;
			endcase
		end
	end

	// address and captured bytes survive a chip reset for debug
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fetch_addr_r <= 16'h0000;
			reset_vector_r <= 16'h0000;
			mode_err_r <= 1'b0;
		end else if (!chip_rst && !ph_r) begin
			unique case (state_r)
				wru_pkg::SEQ_MODE: fetch_addr_r <= wru_pkg::VEC_MODE_ADDR;
				wru_pkg::SEQ_VHI: fetch_addr_r <= wru_pkg::VEC_HI_ADDR;
				wru_pkg::SEQ_VLO: fetch_addr_r <= wru_pkg::VEC_LO_ADDR;
				default: fetch_addr_r <= fetch_addr_r;
			endcase
		end else if (!chip_rst && ph_r && !fetch_rd_r) begin
			unique case (state_r)
				// image must hold zero here; flag it rather than trust it
				wru_pkg::SEQ_MODE: mode_err_r <= (mem_rdata != wru_pkg::MODE_BYTE_RSVD);
				wru_pkg::SEQ_VHI: reset_vector_r[15:8] <= mem_rdata;
				wru_pkg::SEQ_VLO: reset_vector_r[7:0] <= mem_rdata;
				default: reset_vector_r <= reset_vector_r;
			endcase
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || chip_rst);

	a_fetch_order: assert property (fetch_rd_r && fetch_addr_r == wru_pkg::VEC_MODE_ADDR
		|-> ##3 (fetch_rd_r && fetch_addr_r == wru_pkg::VEC_HI_ADDR)
		##3 (fetch_rd_r && fetch_addr_r == wru_pkg::VEC_LO_ADDR))
		else $error("vector fetch out of order");
	a_osc_before_run: assert property (state_r == wru_pkg::SEQ_HOLD && osc_req
		|=> osc_wait_r && !cpu_run_r && !fetch_rd_r)
		else $error("operation resumed without oscillation wait");
	c_fetch_done: cover property (state_r == wru_pkg::SEQ_VLO ##1 cpu_run_r);
	c_stop_resume: cover property (resume && state_r == wru_pkg::SEQ_RUN ##[1:1000] cpu_run_r);
endmodule // wru_seq

// ### bench/tb_watchdog_reset_unit.sv
// self-checking bench for the watchdog reset unit
`timescale 1ns/1ps
module tb_watchdog_reset_unit;
	localparam int OSC = 4;
	localparam int HOLD = 4;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, mem_rdata;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic rst_pin_n, por_req, por_option, tbt_tick, wake;
	logic chip_reset_n_r, cpu_run, fetch_rd, mode_err, sleep_mode_r, stop_mode_r, irq_enable_r, wdt_running_r;
	logic [15:0] fetch_addr, reset_vector, vec;
	logic [15:0] fq[$];
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int bad_count, checks, c0, c1;
	logic [31:0] r;

	wru_top #(.OSC_WAIT_CYCLES(OSC), .RST_HOLD_CYCLES(HOLD)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .rst_pin_n, .por_req, .por_option, .tbt_tick, .wake, .mem_rdata, .chip_reset_n_r, .cpu_run,
		.fetch_addr, .fetch_rd, .reset_vector, .mode_err, .sleep_mode_r, .stop_mode_r, .irq_enable_r,
		.wdt_running_r);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task chk(input logic [33:0] s, input logic [33:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("Error %0t: got %h expected %h", $time, s, e);
		end
	endtask

	task tally_and_finish;
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// memory image and result monitor; the bus lines toggle when nothing is fetched
	always @(posedge aclk) begin
		if (fetch_rd === 1'b1) begin
			chk(fetch_addr, fq.size() ? fq.pop_front() : 'x);
			mem_rdata <= fetch_addr == wru_pkg::VEC_HI_ADDR ? vec[15:8] :
				fetch_addr == wru_pkg::VEC_LO_ADDR ? vec[7:0] : wru_pkg::MODE_BYTE_RSVD;
		end else
			mem_rdata <= ~mem_rdata;
		if (s_axi_bvalid && s_axi_bready)
			chk(s_axi_bresp, bq.size() ? bq.pop_front() : 'x);
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : 'x);
	end

	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		bq.push_back(e);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (1) begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if ((s_axi_bvalid && s_axi_bready) || n > 100) break;
		end
		chk(n > 100, 0);
	endtask

	task axr(input logic [7:0] a, input logic [33:0] e);
		int n;
		n = 0;
		rq.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (1) begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if ((s_axi_rvalid && s_axi_rready) || n > 100) break;
		end
		chk(n > 100, 0);
	endtask

	task tick;
		tbt_tick <= 1'b1;
		@(posedge aclk);
		tbt_tick <= 1'b0;
		@(posedge aclk);
	endtask

	task pulse_wake;
		wake <= 1'b1;
		@(posedge aclk);
		wake <= 1'b0;
	endtask

	task no_rst(input int m);
		int n;
		n = 0;
		repeat (m) begin
			@(posedge aclk);
			if (chip_reset_n_r !== 1'b1) n++;
		end
		chk(n, 0);
	endtask

	task got_rst;
		int n, l;
		n = 0;
		l = 0;
		while (chip_reset_n_r !== 1'b0 && n < 10) begin
			@(posedge aclk);
			n++;
		end
		while (chip_reset_n_r !== 1'b1 && l < 100) begin
			@(posedge aclk);
			l++;
		end
		chk(n < 10, 1);
		chk(l >= HOLD, 1);
	endtask

	task exp_boot;
		vec = 16'($urandom);
		fq.push_back(wru_pkg::VEC_MODE_ADDR);
		fq.push_back(wru_pkg::VEC_HI_ADDR);
		fq.push_back(wru_pkg::VEC_LO_ADDR);
	endtask

	task wait_run(output int c);
		c = 0;
		while (cpu_run !== 1'b1 && c < 3000) begin
			@(posedge aclk);
			c++;
		end
		chk(cpu_run, 1);
	endtask

	task boot_done(output int c);
		wait_run(c);
		chk(reset_vector, vec);
		chk(fq.size(), 0);
		chk(irq_enable_r, 0);
		chk(wdt_running_r, 0);
		chk(mode_err, 0);
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		tally_and_finish();
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		// answers always accepted, so back-to-back calls never re-drive a ready
		{s_axi_bready, s_axi_rready} = 2'b11;
		{s_axi_awaddr, s_axi_araddr, mem_rdata, s_axi_wdata, por_req, por_option, tbt_tick, wake} = '0;
		s_axi_wstrb = 4'hf;
		rst_pin_n = 1'b1;
		bad_count = 0;
		checks = 0;
		void'($urandom(32'h9e0a));
		exp_boot();
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		boot_done(c0);
		axr(wru_pkg::OFF_WDT_CTRL, 34'h0000000f);
		axr(8'h0c, {wru_pkg::RESP_SLVERR, 32'h0});
		axw(8'h0c, 32'h5, wru_pkg::RESP_SLVERR);
		axw(wru_pkg::OFF_WDT_CTRL, 32'h3, wru_pkg::RESP_OKAY);
		chk(wdt_running_r, 0);
		repeat (3) tick();
		no_rst(8);
		r = $urandom;
		r[3:0] = wru_pkg::WDT_KEY;
		axw(wru_pkg::OFF_WDT_CTRL, r, wru_pkg::RESP_OKAY);
		chk(wdt_running_r, 1);
		axw(wru_pkg::OFF_WDT_CTRL, 32'ha, wru_pkg::RESP_OKAY);
		chk(wdt_running_r, 1);
		axr(wru_pkg::OFF_WDT_CTRL, 34'h0000000f);
		tick();
		axw(wru_pkg::OFF_WDT_CTRL, 32'h5, wru_pkg::RESP_OKAY);
		tick();
		no_rst(200);
		axw(wru_pkg::OFF_STBY_CTRL, 32'h3, wru_pkg::RESP_OKAY);
		chk(sleep_mode_r, 1);
		repeat (3) tick();
		no_rst(8);
		pulse_wake();
		tick();
		no_rst(8);
		exp_boot();
		tick();
		got_rst();
		boot_done(c0);
		axr(wru_pkg::OFF_STATUS, 34'h00000010);
		axw(wru_pkg::OFF_STBY_CTRL, 32'h9, wru_pkg::RESP_OKAY);
		chk(irq_enable_r, 1);
		exp_boot();
		axw(wru_pkg::OFF_STBY_CTRL, 32'h0, wru_pkg::RESP_OKAY);
		got_rst();
		boot_done(c0);
		axr(wru_pkg::OFF_STATUS, 34'h00000004);
		exp_boot();
		rst_pin_n <= 1'b0;
		fork
			got_rst();
			begin
				repeat (6) @(posedge aclk);
				rst_pin_n <= 1'b1;
			end
		join
		boot_done(c0);
		axr(wru_pkg::OFF_STATUS, 34'h00000002);
		por_req <= 1'b1;
		@(posedge aclk);
		por_req <= 1'b0;
		no_rst(20);
		exp_boot();
		por_option <= 1'b1;
		por_req <= 1'b1;
		@(posedge aclk);
		por_req <= 1'b0;
		por_option <= 1'b0;
		got_rst();
		boot_done(c1);
		chk(c1 >= c0 + OSC, 1);
		axr(wru_pkg::OFF_STATUS, 34'h00000008);
		axw(wru_pkg::OFF_WDT_CTRL, 32'h5, wru_pkg::RESP_OKAY);
		tick();
		axw(wru_pkg::OFF_STBY_CTRL, 32'h5, wru_pkg::RESP_OKAY);
		chk(stop_mode_r, 1);
		pulse_wake();
		repeat (2) @(posedge aclk);
		chk(cpu_run, 0);
		wait_run(c1);
		chk(c1 >= OSC - 2, 1);
		chk(stop_mode_r, 0);
		tick();
		no_rst(8);
		exp_boot();
		tick();
		got_rst();
		boot_done(c0);
		chk(bq.size() + rq.size(), 0);
		tally_and_finish();
	end
endmodule // tb_watchdog_reset_unit
